// ==== shared/oled_cmd_pkg.sv ====
// Package with register map, opcodes, reset values and parameter counts of the OLED command decoder.
package oled_cmd_pkg;

  // APB register byte offsets.
  localparam logic [7:0] OFS_CMD_BYTE   = 8'h00;
  localparam logic [7:0] OFS_DATA_BYTE  = 8'h04;
  localparam logic [7:0] OFS_STATUS     = 8'h08;
  localparam logic [7:0] OFS_CFG_A      = 8'h0c;
  localparam logic [7:0] OFS_CFG_B      = 8'h10;
  localparam logic [7:0] OFS_CFG_C      = 8'h14;
  localparam logic [7:0] OFS_BANK_COLOR = 8'h18;
  localparam logic [7:0] OFS_CTRL       = 8'h1c;

  // Opcodes.
  localparam logic [7:0] OP_BANK_COLOR_HI = 8'h93;
  localparam logic [7:0] OP_SEG_REMAP     = 8'ha0;
  localparam logic [7:0] OP_ENTIRE_ON     = 8'ha4;
  localparam logic [7:0] OP_INVERSE       = 8'ha6;
  localparam logic [7:0] OP_MUX_RATIO     = 8'ha8;
  localparam logic [7:0] OP_DIM_SETUP     = 8'hab;
  localparam logic [7:0] OP_DISP_DIM      = 8'hac;
  localparam logic [7:0] OP_MASTER_CFG    = 8'had;
  localparam logic [7:0] OP_DISP_OFF      = 8'hae;
  localparam logic [7:0] OP_DISP_NORMAL   = 8'haf;
  localparam logic [7:0] OP_PAGE_START    = 8'hb0;
  localparam logic [7:0] OP_COM_SCAN      = 8'hc0;
  localparam logic [7:0] OP_DISP_OFFSET   = 8'hd3;
  localparam logic [7:0] OP_CLOCK_DIV     = 8'hd5;
  localparam logic [7:0] OP_AREA_COLOR    = 8'hd8;
  localparam logic [7:0] OP_PRECHARGE     = 8'hd9;
  localparam logic [7:0] OP_COM_PINS      = 8'hda;
  localparam logic [7:0] OP_DESELECT      = 8'hdb;
  localparam logic [7:0] OP_RMW_ENTER     = 8'he0;
  localparam logic [7:0] OP_NOP           = 8'he3;
  localparam logic [7:0] OP_RMW_EXIT      = 8'hee;
  localparam logic [7:0] SUPPLY_EXTERNAL  = 8'hae;

  // Reset values.
  localparam logic [5:0] RST_MUX_N     = 6'h3f;
  localparam logic [5:0] MUX_N_MIN     = 6'h0f;
  localparam logic [3:0] RST_CLK_DIV   = 4'h0;
  localparam logic [3:0] RST_OSC_FREQ  = 4'h7;
  localparam logic [3:0] RST_PHASE     = 4'h2;
  localparam logic [3:0] RST_DESELECT  = 4'hd;
  localparam logic [1:0] RST_ADDR_MODE = 2'h2;
  localparam logic [1:0] ADDR_MODE_PAGE = 2'h2;

  typedef enum logic [1:0] {DISP_OFF, DISP_ON_DIM, DISP_ON_NORMAL} disp_state_t;
  typedef enum logic {ST_OPCODE, ST_PARAM} dec_state_t;

  // Number of parameter bytes that follow each opcode.
  function automatic logic [2:0] param_count(input logic [7:0] op);
    logic [2:0] n;
    n = 3'h0;
    case (op)
      OP_BANK_COLOR_HI: n = 3'h4;
      OP_DIM_SETUP:     n = 3'h3;
      OP_MUX_RATIO, OP_MASTER_CFG, OP_DISP_OFFSET, OP_CLOCK_DIV, OP_AREA_COLOR,
      OP_PRECHARGE, OP_COM_PINS, OP_DESELECT: n = 3'h1;
      default:          n = 3'h0;
    endcase
    return n;
  endfunction : param_count

endpackage : oled_cmd_pkg

// ==== core/oled_command_decoder.sv ====
// Command byte decoder of a small graphic OLED controller, reached over APB.
//
// What this block does
// - Opcode A0/A1 low bit picks column 0 or 131 on first segment; reset 0.
// - A4 follows display RAM, A5 forces all pixels on; reset follows RAM.
// - A6 normal polarity, A7 inverted; reset normal.
// - A8 plus one byte sets multiplex ratio N+1; N below 15 invalid; reset 64.
// - AB takes three bytes: reserved, dim contrast for base bank, dim brightness.
// - AD takes one byte; AE selects external supply, also the reset setting.
// - AC dim on, AE off, AF normal on; display is off after reset.
// - B0-B7 load low three bits as page start address.
// - C0/C8 bit 3 picks normal or reversed row scan; reset normal.
// - D3 plus one byte sets row shift 0 to 63; reset zero.
// - D5 byte: low nibble clock divide minus one, high nibble oscillator; resets 0,7.
// - D8 byte: bits 5:4 colour mode, bits 2 and 0 low power; reset 00.
// - D9 byte: phase 1 low nibble, phase 2 high nibble; zero forbidden, but stored as written; reset 2.
// - DA byte: bit 4 alternative pins, bit 5 left/right remap; both reset 1.
// - DB byte bits 5:2 set row deselect level; reset 1101b.
// - E0 enters read-modify-write mode, EE leaves it.
// - E3 is accepted and changes nothing.
// - Bank colour command takes four bytes of 2-bit colours, banks 17 to 32.
// - Page start applies only while addressing mode is page mode (10b).
`timescale 1ns/10ps
module oled_command_decoder
  import oled_cmd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             seg_remap,
  output logic             entire_on,
  output logic             inverse_on,
  output logic [6:0]       multiplex_ratio,
  output logic             com_scan_rev,
  output logic [1:0]       display_state,
  output logic [2:0]       page_start,
  output logic             page_start_active,
  output logic             rmw_mode,
  output logic [7:0]       display_data,
  output logic             display_data_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode. Every access completes in its first access cycle.

  logic        apb_wr;
  logic        apb_rd;
  logic        hit_cmd;
  logic        hit_data;
  logic        hit_status;
  logic        hit_cfg_a;
  logic        hit_cfg_b;
  logic        hit_cfg_c;
  logic        hit_bank;
  logic        hit_ctrl;
  logic        hit_any;
  logic        cmd_wr;
  logic        data_wr;
  logic        ctrl_wr;
  logic [7:0]  byte_in;

  assign apb_wr     = psel & penable & pwrite;
  assign apb_rd     = psel & penable & ~pwrite;
  assign hit_cmd    = (paddr == OFS_CMD_BYTE);
  assign hit_data   = (paddr == OFS_DATA_BYTE);
  assign hit_status = (paddr == OFS_STATUS);
  assign hit_cfg_a  = (paddr == OFS_CFG_A);
  assign hit_cfg_b  = (paddr == OFS_CFG_B);
  assign hit_cfg_c  = (paddr == OFS_CFG_C);
  assign hit_bank   = (paddr == OFS_BANK_COLOR);
  assign hit_ctrl   = (paddr == OFS_CTRL);
  assign hit_any    = hit_cmd | hit_data | hit_status | hit_cfg_a
                    | hit_cfg_b | hit_cfg_c | hit_bank | hit_ctrl;
  // The command and data ports stand in for the select line: each has its own address.
  assign cmd_wr     = apb_wr & hit_cmd;
  assign data_wr    = apb_wr & hit_data;
  assign ctrl_wr    = apb_wr & hit_ctrl;
  assign byte_in    = pwdata[7:0];
  // Zero wait states: every register and setting settles within one clock.
  assign pready     = 1'b1;
  // Unmapped offsets answer with an error; writes to read-only offsets are dropped silently.
  assign pslverr    = psel & penable & ~hit_any;

  ////////////////////////////////////////////////////////////////////////////
  // Settings state.

  dec_state_t  state_r;
  logic [7:0]  cur_op_r;
  logic [2:0]  idx_r;
  logic        seg_remap_r;
  logic        entire_on_r;
  logic        inverse_r;
  logic [5:0]  mux_n_r;
  logic [7:0]  dim_contrast_r;
  logic [7:0]  dim_bright_r;
  logic        ext_supply_r;
  disp_state_t disp_r;
  logic [2:0]  page_start_r;
  logic        com_rev_r;
  logic [5:0]  offset_r;
  logic [3:0]  clk_div_r;
  logic [3:0]  osc_freq_r;
  logic [1:0]  color_mode_r;
  logic [1:0]  low_power_r;
  logic [3:0]  phase1_r;
  logic [3:0]  phase2_r;
  logic        com_alt_r;
  logic        com_lr_r;
  logic [3:0]  deselect_r;
  logic        rmw_r;
  logic [31:0] bank_color_r;
  logic [1:0]  addr_mode_r;
  logic [7:0]  data_r;
  logic        data_valid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Byte classification.

  logic       take_op;
  logic       take_par;
  logic [2:0] op_params;
  logic       last_par;
  logic       par_first;
  logic       par_second;
  logic       par_third;

  assign take_op    = cmd_wr & (state_r == ST_OPCODE);
  assign take_par   = cmd_wr & (state_r == ST_PARAM);
  // The lookup gives how many bytes must follow the opcode now being written.
  assign op_params  = param_count(byte_in);
  assign last_par   = ((idx_r + 3'h1) == param_count(cur_op_r));
  assign par_first  = take_par & (idx_r == 3'h0);
  assign par_second = take_par & (idx_r == 3'h1);
  assign par_third  = take_par & (idx_r == 3'h2);

  // Single-byte opcodes, matched with their variable bits masked off.
  logic is_seg;
  logic is_entire;
  logic is_inv;
  logic is_page;
  logic is_scan;
  logic is_dim_on;
  logic is_off;
  logic is_norm_on;
  logic is_rmw_in;
  logic is_rmw_out;

  assign is_seg     = take_op & ((byte_in & 8'hfe) == OP_SEG_REMAP);
  assign is_entire  = take_op & ((byte_in & 8'hfe) == OP_ENTIRE_ON);
  assign is_inv     = take_op & ((byte_in & 8'hfe) == OP_INVERSE);
  assign is_page    = take_op & ((byte_in & 8'hf8) == OP_PAGE_START);
  // Bit 3 is the only variable bit of the row scan opcode, so the mask clears it alone.
  assign is_scan    = take_op & ((byte_in & 8'hf7) == OP_COM_SCAN);
  assign is_dim_on  = take_op & (byte_in == OP_DISP_DIM);
  assign is_off     = take_op & (byte_in == OP_DISP_OFF);
  assign is_norm_on = take_op & (byte_in == OP_DISP_NORMAL);
  assign is_rmw_in  = take_op & (byte_in == OP_RMW_ENTER);
  assign is_rmw_out = take_op & (byte_in == OP_RMW_EXIT);

  // One-parameter commands take effect on their only parameter byte.
  logic par_mux;
  logic par_master;
  logic par_offset;
  logic par_clk;
  logic par_area;
  logic par_pre;
  logic par_pins;
  logic par_desel;
  logic par_dim_b;
  logic par_dim_c;
  logic par_bank;

  assign par_mux    = par_first & (cur_op_r == OP_MUX_RATIO);
  assign par_master = par_first & (cur_op_r == OP_MASTER_CFG);
  assign par_offset = par_first & (cur_op_r == OP_DISP_OFFSET);
  assign par_clk    = par_first & (cur_op_r == OP_CLOCK_DIV);
  assign par_area   = par_first & (cur_op_r == OP_AREA_COLOR);
  assign par_pre    = par_first & (cur_op_r == OP_PRECHARGE);
  assign par_pins   = par_first & (cur_op_r == OP_COM_PINS);
  assign par_desel  = par_first & (cur_op_r == OP_DESELECT);
  // The first dim-mode byte is reserved and only consumed.
  assign par_dim_b  = par_second & (cur_op_r == OP_DIM_SETUP);
  assign par_dim_c  = par_third & (cur_op_r == OP_DIM_SETUP);
  assign par_bank   = take_par & (cur_op_r == OP_BANK_COLOR_HI);

  ////////////////////////////////////////////////////////////////////////////
  // Decoder sequencing.
  // A multi-byte opcode parks its code in cur_op_r, so its parameter bytes never reach the opcode match.

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r  <= ST_OPCODE;
      cur_op_r <= OP_NOP;
      idx_r    <= 3'h0;
    end else if (take_op && op_params != 3'h0) begin
      state_r  <= ST_PARAM;
      cur_op_r <= byte_in;
      idx_r    <= 3'h0;
    end else if (take_par) begin
      // Unknown opcodes never reach here: they count zero parameters.
      state_r  <= last_par ? ST_OPCODE : ST_PARAM;
      idx_r    <= idx_r + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Single-byte settings. NOP and unknown opcodes match none of these.

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      seg_remap_r  <= 1'b0;
      entire_on_r  <= 1'b0;
      inverse_r    <= 1'b0;
      com_rev_r    <= 1'b0;
      page_start_r <= 3'h0;
      rmw_r        <= 1'b0;
    end else begin
      if (is_seg) seg_remap_r <= byte_in[0];
      if (is_entire) entire_on_r <= byte_in[0];
      if (is_inv) inverse_r <= byte_in[0];
      if (is_scan) com_rev_r <= byte_in[3];
      if (is_page) page_start_r <= byte_in[2:0];
      if (is_rmw_in) rmw_r <= 1'b1;
      else if (is_rmw_out) rmw_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      disp_r <= DISP_OFF;
    end else if (is_dim_on) begin
      disp_r <= DISP_ON_DIM;
    end else if (is_off) begin
      disp_r <= DISP_OFF;
    end else if (is_norm_on) begin
      disp_r <= DISP_ON_NORMAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameterised settings.

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mux_n_r      <= RST_MUX_N;
      ext_supply_r <= 1'b1;
      offset_r     <= 6'h00;
      clk_div_r    <= RST_CLK_DIV;
      osc_freq_r   <= RST_OSC_FREQ;
      color_mode_r <= 2'h0;
      low_power_r  <= 2'h0;
    end else begin
      // An invalid ratio is dropped so the panel never scans fewer than 16 rows.
      if (par_mux && byte_in[5:0] >= MUX_N_MIN) mux_n_r <= byte_in[5:0];
      if (par_master) ext_supply_r <= (byte_in == SUPPLY_EXTERNAL);
      if (par_offset) offset_r <= byte_in[5:0];
      if (par_clk) begin
        clk_div_r  <= byte_in[3:0];
        osc_freq_r <= byte_in[7:4];
      end
      if (par_area) begin
        color_mode_r <= byte_in[5:4];
        low_power_r  <= {byte_in[2], byte_in[0]};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase1_r       <= RST_PHASE;
      phase2_r       <= RST_PHASE;
      com_alt_r      <= 1'b1;
      com_lr_r       <= 1'b1;
      deselect_r     <= RST_DESELECT;
      dim_contrast_r <= 8'h00;
      dim_bright_r   <= 8'h00;
    end else begin
      // Zero periods are the host's to avoid; they are stored as written.
      if (par_pre) begin
        phase1_r <= byte_in[3:0];
        phase2_r <= byte_in[7:4];
      end
      if (par_pins) begin
        com_alt_r <= byte_in[4];
        com_lr_r  <= byte_in[5];
      end
      if (par_desel) deselect_r <= byte_in[5:2];
      if (par_dim_b) dim_contrast_r <= byte_in;
      if (par_dim_c) dim_bright_r <= byte_in;
    end
  end

  // Bank 17 lands in bits 1:0, bank 32 in bits 31:30.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bank_color_r <= 32'h0000_0000;
    end else if (par_bank) begin
      bank_color_r[{idx_r[1:0], 3'h0} +: 8] <= byte_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software control and display data pass-through.
  // Display data never enters the command decoder; each data write gives one valid pulse.

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      addr_mode_r  <= RST_ADDR_MODE;
      data_r       <= 8'h00;
      data_valid_r <= 1'b0;
    end else begin
      if (ctrl_wr) addr_mode_r <= pwdata[1:0];
      data_valid_r <= data_wr;
      if (data_wr) data_r <= byte_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and outputs.

  logic [31:0] status_word;
  logic [31:0] cfg_a_word;
  logic [31:0] cfg_b_word;
  logic [31:0] cfg_c_word;
  logic [31:0] ctrl_word;

  // Status holds the waiting flag in bit 0, the parameter index in bits 4:2 and the opcode in bits 15:8.
  assign status_word = {16'h0000, cur_op_r, 3'h0, idx_r, 1'b0, (state_r == ST_PARAM)};
  // The single-byte settings sit above the six-bit ratio field.
  assign cfg_a_word  = {13'h0000, page_start_r, 1'b0, ext_supply_r, rmw_r, com_rev_r, disp_r, inverse_r,
                        entire_on_r, seg_remap_r, 1'b0, mux_n_r};
  // D5, D9 and the dim bytes read back as written; the D8 fields are moved and the DA bits share a byte lane with DB.
  assign cfg_b_word  = {phase2_r, phase1_r, 1'b0, low_power_r[1], 1'b0, low_power_r[0], 2'h0, color_mode_r,
                        osc_freq_r, clk_div_r, 2'h0, offset_r};
  assign cfg_c_word  = {8'h00, dim_bright_r, dim_contrast_r, 2'h0, deselect_r, com_lr_r, com_alt_r};
  // The addressing mode is the only writable field, as no command of this block reaches it.
  assign ctrl_word   = {30'h0000_0000, addr_mode_r};

  always_comb begin
    prdata = 32'h0000_0000;
    if (apb_rd) begin
      case (1'b1)
        hit_status: prdata = status_word;
        hit_cfg_a:  prdata = cfg_a_word;
        hit_cfg_b:  prdata = cfg_b_word;
        hit_cfg_c:  prdata = cfg_c_word;
        hit_bank:   prdata = bank_color_r;
        hit_ctrl:   prdata = ctrl_word;
        default:    prdata = 32'h0000_0000;
      endcase
    end
  end

  assign seg_remap          = seg_remap_r;
  assign entire_on          = entire_on_r;
  assign inverse_on         = inverse_r;
  assign multiplex_ratio    = {1'b0, mux_n_r} + 7'h01;
  assign com_scan_rev       = com_rev_r;
  assign display_state      = disp_r;
  assign page_start         = page_start_r;
  assign page_start_active  = (addr_mode_r == ADDR_MODE_PAGE);
  assign rmw_mode           = rmw_r;
  assign display_data       = data_r;
  assign display_data_valid = data_valid_r;

endmodule : oled_command_decoder

// ==== dv/oled_host_model.sv ====
// Host processor model that writes command, parameter and display bytes over APB.
`timescale 1ns/10ps
module oled_host_model
  import oled_cmd_pkg::*;
(
  input  wire logic        ref_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  int unsigned gap = 0;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'hff;
    pwdata  = 32'h0;
  end

  // Released address and data lines show the inverse of their last value so no stale request can pass for a fresh one.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~wd;
    @(posedge ref_clk);
    repeat (gap) @(posedge ref_clk);
  endtask : xfer

  task automatic cmd(input logic [7:0] b);
    logic [31:0] d;
    logic        e;
    xfer(1'b1, OFS_CMD_BYTE, {24'h0, b}, d, e);
  endtask : cmd

  task automatic data(input logic [7:0] b);
    logic [31:0] d;
    logic        e;
    xfer(1'b1, OFS_DATA_BYTE, {24'h0, b}, d, e);
  endtask : data
endmodule : oled_host_model

// ==== dv/oled_command_decoder_checker.sv ====
// Checker tying the decoder's settings outputs to the bytes written over APB.
`timescale 1ns/10ps
module oled_command_decoder_checker
  import oled_cmd_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        seg_remap,
  input wire logic        entire_on,
  input wire logic        inverse_on,
  input wire logic [6:0]  multiplex_ratio,
  input wire logic        com_scan_rev,
  input wire logic [1:0]  display_state,
  input wire logic [2:0]  page_start,
  input wire logic        rmw_mode,
  input wire logic [7:0]  display_data,
  input wire logic        display_data_valid
);
  logic [2:0] pend_r;
  logic [2:0] pend_nxt;
  logic [7:0] op_r;
  wire        wr_acc = psel & penable & pwrite & pready;
  wire        cmd_wr = wr_acc & (paddr == OFS_CMD_BYTE);
  wire        op_wr  = cmd_wr & (pend_r == 3'h0);
  wire [7:0]  b      = pwdata[7:0];

  // Own count of pending parameter bytes, kept apart from the design's table on purpose.
  always_comb begin
    pend_nxt = pend_r;
    if (cmd_wr && pend_r != 3'h0) pend_nxt = pend_r - 3'h1;
    else if (op_wr) begin
      case (b)
        8'h93:   pend_nxt = 3'h4;
        8'hab:   pend_nxt = 3'h3;
        8'ha8, 8'had, 8'hd3, 8'hd5, 8'hd8, 8'hd9, 8'hda, 8'hdb: pend_nxt = 3'h1;
        default: pend_nxt = 3'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pend_r <= 3'h0;
      op_r   <= 8'he3;
    end else begin
      pend_r <= pend_nxt;
      if (op_wr) op_r <= b;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_seg_remap_set: assert property (op_wr && b[7:1] == 7'h50 |=> seg_remap == $past(b[0]))
    else $error("segment remap does not follow opcode");
  a_entire_on_set: assert property (op_wr && b[7:1] == 7'h52 |=> entire_on == $past(b[0]))
    else $error("entire display does not follow opcode");
  a_inverse_set: assert property (op_wr && b[7:1] == 7'h53 |=> inverse_on == $past(b[0]))
    else $error("inverse display does not follow opcode");
  a_mux_ratio_load: assert property (cmd_wr && pend_r == 3'h1 && op_r == 8'ha8 && b[5:0] >= 6'h0f
    |=> multiplex_ratio == {1'b0, $past(b[5:0])} + 7'h1) else $error("multiplex ratio not loaded");
  a_display_state: assert property (op_wr && (b == 8'hac || b == 8'hae || b == 8'haf)
    |=> display_state == ($past(b[1:0]) == 2'h0 ? 2'h1 : ($past(b[1:0]) == 2'h2 ? 2'h0 : 2'h2)))
    else $error("display state does not follow opcode");
  a_page_start_load: assert property (op_wr && b[7:3] == 5'h16 |=> page_start == $past(b[2:0]))
    else $error("page start not loaded");
  a_com_scan_set: assert property (op_wr && (b == 8'hc0 || b == 8'hc8) |=> com_scan_rev == $past(b[3]))
    else $error("row scan direction does not follow opcode");
  a_rmw_mode_set: assert property (op_wr && (b == 8'he0 || b == 8'hee) |=> rmw_mode == !$past(b[1]))
    else $error("read modify write mode does not follow opcode");
  a_nop_no_change: assert property ((op_wr && b == 8'he3) or (cmd_wr && pend_r != 3'h0)
    |=> $stable({seg_remap, entire_on, inverse_on, com_scan_rev, display_state, page_start, rmw_mode}))
    else $error("settings changed by a byte that is not a setting opcode");
  a_data_byte_pass: assert property (wr_acc && paddr == OFS_DATA_BYTE
    |=> display_data_valid && display_data == $past(b)) else $error("display data byte not passed on");
endmodule : oled_command_decoder_checker

bind oled_command_decoder oled_command_decoder_checker chk_u (
  .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .seg_remap(seg_remap), .entire_on(entire_on), .inverse_on(inverse_on),
  .multiplex_ratio(multiplex_ratio), .com_scan_rev(com_scan_rev), .display_state(display_state),
  .page_start(page_start), .rmw_mode(rmw_mode), .display_data(display_data),
  .display_data_valid(display_data_valid)
);

// ==== dv/oled_command_decoder_test.sv ====
// Self-checking testbench of the OLED command decoder driven through the host model.
`timescale 1ns/10ps
module oled_command_decoder_test
  import oled_cmd_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, display_data;
  logic [31:0] pwdata, prdata;
  logic        seg_remap, entire_on, inverse_on, com_scan_rev, page_start_active, rmw_mode, display_data_valid;
  logic [6:0]  multiplex_ratio;
  logic [1:0]  display_state;
  logic [2:0]  page_start;
  int          miscompares = 0;
  int          n_checks = 0;
  wire  [31:0] st = {22'h0, page_start, display_state, rmw_mode, com_scan_rev, inverse_on, entire_on, seg_remap};

  always #4 ref_clk = ~ref_clk;

  oled_host_model host_u (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  oled_command_decoder dut_u (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .seg_remap(seg_remap),
    .entire_on(entire_on), .inverse_on(inverse_on), .multiplex_ratio(multiplex_ratio),
    .com_scan_rev(com_scan_rev), .display_state(display_state), .page_start(page_start),
    .page_start_active(page_start_active), .rmw_mode(rmw_mode), .display_data(display_data),
    .display_data_valid(display_data_valid));

  task automatic complete_run;
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Every read also checks the error flag: it expects an error only for offsets past the control register.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    host_u.xfer(1'b0, a, 32'h0, d, e);
    chk(d, exp);
    chk({31'h0, e}, {31'h0, a > OFS_CTRL});
  endtask : rd

  task automatic cmds(input logic [7:0] q[]);
    foreach (q[i]) host_u.cmd(q[i]);
  endtask : cmds

  initial begin
    logic [31:0] d;
    logic        e;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk(st, 32'h0);
    chk({25'h0, multiplex_ratio}, 32'h40);
    chk({31'h0, page_start_active}, 32'h1);
    rd(OFS_CFG_A, 32'h0000403f);
    rd(OFS_STATUS, 32'h0000e300);
    rd(OFS_CFG_B, 32'h22007000);
    rd(OFS_CFG_C, 32'h00000037);
    rd(OFS_CTRL, 32'h00000002);
    rd(8'h20, 32'h0);
    host_u.xfer(1'b1, OFS_CFG_A, 32'hffffffff, d, e);
    rd(OFS_CFG_A, 32'h0000403f);
    cmds('{8'ha1, 8'ha5, 8'ha7, 8'hc8, 8'hb5, 8'haf, 8'he0});
    chk(st, 32'h2df);
    cmds('{8'ha0, 8'ha4, 8'ha6, 8'hc0, 8'hb0, 8'hac, 8'hee});
    chk(st, 32'h020);
    cmds('{8'hae, 8'ha8});
    rd(OFS_STATUS, 32'h0000a801);
    cmds('{8'h1f});
    chk({25'h0, multiplex_ratio}, 32'h20);
    cmds('{8'ha8, 8'h0e});
    chk({25'h0, multiplex_ratio}, 32'h20);
    cmds('{8'ha8, 8'h0f});
    chk({25'h0, multiplex_ratio}, 32'h10);
    host_u.gap = 3;
    cmds('{8'hd3, 8'ha1, 8'hd5, 8'hf3, 8'hd8, 8'h35, 8'hd9, 8'hd2});
    chk(st, 32'h0);
    rd(OFS_CFG_B, 32'hd253f321);
    host_u.gap = 0;
    cmds('{8'hda, 8'h00, 8'hdb, 8'h3c, 8'hab, 8'h00, 8'h12, 8'h34});
    rd(OFS_CFG_C, 32'h0034123c);
    cmds('{8'had, 8'h8e});
    rd(OFS_CFG_A, 32'h0000000f);
    cmds('{8'had, 8'hae, 8'h93, 8'h1b, 8'he4, 8'h55, 8'haa});
    rd(OFS_BANK_COLOR, 32'haa55e41b);
    rd(OFS_CFG_A, 32'h0000400f);
    cmds('{8'he3, 8'h20, 8'h82, 8'ha1});
    chk(st, 32'h001);
    host_u.data(8'ha5);
    chk({st[7:0], display_data}, 32'h01a5);
    host_u.xfer(1'b1, OFS_CTRL, 32'h0, d, e);
    chk({31'h0, page_start_active}, 32'h0);
    host_u.xfer(1'b1, OFS_CTRL, 32'h2, d, e);
    chk({31'h0, page_start_active}, 32'h1);
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end
endmodule : oled_command_decoder_test
